// file: core/fsa_consts.svh
// Constants shared by the flow sample averager files
`ifndef FSA_CONSTS_SVH
`define FSA_CONSTS_SVH

// Clock period and documented times, in ns
`define FSA_CLK_NS       4
`define FSA_T_SAMPLE_NS  500000
`define FSA_T_TEMP_NS    12000000
`define FSA_T_AVG_NS     100000000
`define FSA_T_PWRUP_NS   25000000
`define FSA_T_INIT_NS    12000000
`define FSA_T_WARM_NS    60000000

// Counter widths sized for the counts above
`define FSA_SMP_W        17
`define FSA_TMP_W        22
`define FSA_IVL_W        25
`define FSA_TMR_W        24
`define FSA_PU_W         23

// Host commands
`define FSA_CMD_START_H2O 16'h3608
`define FSA_CMD_START_IPA 16'h3615
`define FSA_CMD_STOP      16'h3FF9

// Flag word bit positions
`define FSA_FLG_AIR      0
`define FSA_FLG_HIGH     1
`define FSA_FLG_EMA      5

// Smoothing factor 0.0125 in Q16, flow limit in raw counts
`define FSA_ALPHA_Q16    17'h00333
`define FSA_FLOW_LIMIT   16'h0CB2

// Result words per read and data FIFO shape
`define FSA_WORDS        2'h3
`define FSA_WORD_W       16
`define FSA_FIFO_DEPTH   8

`endif

// file: core/fsa_pkg.sv
// Types of the flow sample averager
`include "fsa_consts.svh"
package fsa_pkg;
    typedef enum logic [2:0] {
        FSA_IDLE = 3'b001,
        FSA_INIT = 3'b010,
        FSA_RUN  = 3'b100
    } fsa_mode_t;

    typedef struct packed {
        logic [15:0] flow;
        logic [15:0] temp;
        logic [15:0] flags;
    } fsa_result_t;

    typedef struct packed {
        logic cmd_m, cmd_s, cmd_seen, rd_m, rd_s, rd_seen, xack_m, xack_s, xack_seen;
        logic air_m, air_s, en_m, en_s;
        fsa_mode_t mode;
        logic heater, med, ready, warm, avail, unread, alert_n;
        logic [`FSA_PU_W-1:0] pu_cnt;
        logic [`FSA_TMR_W-1:0] tmr;
        logic [`FSA_SMP_W-1:0] smp_cnt;
        logic [`FSA_TMP_W-1:0] tmp_cnt;
        logic [`FSA_IVL_W-1:0] ivl;
        logic signed [31:0] sum;
        logic [15:0] cnt;
        logic ema;
        logic signed [23:0] ema_s;
        logic [15:0] last_flow, temp;
        logic f_air, f_high;
        fsa_result_t snap;
        logic [1:0] push_idx;
        logic xbusy, xreq;
        logic [15:0] xdat;
    } fsa_ref_st_t;

    typedef struct packed {
        logic rdy_m, rdy_s, avl_m, avl_s, xreq_m, xreq_s, xreq_seen;
        logic cmd_tgl, rd_tgl, xack_tgl;
        logic [15:0] cmd;
        logic reading;
        logic [1:0] out_cnt;
        logic [15:0] word;
        logic word_valid, hdr_ack, hdr_nack;
    } fsa_link_st_t;
endpackage

// file: core/fsa_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module fsa_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Filling side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Draining side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } fsa_fifo_st_t;

    fsa_fifo_st_t s, next_s;
    logic         push;
    logic         pop;

    // Handshakes and flags straight from the stored state
    assign in_ready_o  = (s.cnt != (AW+1)'(D));
    assign out_valid_o = (s.cnt != '0);
    assign out_data_o  = s.mem[s.rp];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Pointer and count update
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = in_data_i;
            next_s.wp        = (s.wp == AW'(D-1)) ? '0 : s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + 1'b1;
        end
        next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

// file: core/fsa_top.sv
// Flow sample averager: sampling loop, averaging, flags and host readout link
`timescale 1ns/1ps
`default_nettype none
`include "fsa_consts.svh"
module fsa_top #(
    parameter int unsigned SAMPLE_CYC = `FSA_T_SAMPLE_NS / `FSA_CLK_NS,
    parameter int unsigned TEMP_CYC   = `FSA_T_TEMP_NS / `FSA_CLK_NS,
    parameter int unsigned AVG_CYC    = `FSA_T_AVG_NS / `FSA_CLK_NS,
    parameter int unsigned PWRUP_CYC  = `FSA_T_PWRUP_NS / `FSA_CLK_NS,
    parameter int unsigned INIT_CYC   = (`FSA_T_INIT_NS + `FSA_CLK_NS - 1) / `FSA_CLK_NS,
    parameter int unsigned WARM_CYC   = (`FSA_T_WARM_NS + `FSA_CLK_NS - 1) / `FSA_CLK_NS
) (
    // Clocks and reset
    input  wire logic        ref_clk_i,
    input  wire logic        link_clk_i,
    input  wire logic        rst_n_i,
    // Sensing front end, on ref_clk_i
    input  wire logic [15:0] flow_adc_i,
    input  wire logic [15:0] temp_adc_i,
    // Asynchronous pins
    input  wire logic        air_det_i,
    input  wire logic        alert_en_i,
    // Status, on ref_clk_i
    output logic             heater_on_o,
    output logic             medium_ipa_o,
    output logic             warm_o,
    output logic             new_result_alert_n_o,
    // Host link, on link_clk_i
    input  wire logic        cmd_valid_i,
    input  wire logic [15:0] cmd_i,
    input  wire logic        rd_hdr_i,
    input  wire logic        rd_stop_i,
    input  wire logic        word_ready_i,
    output logic             hdr_ack_o,
    output logic             hdr_nack_o,
    output logic [15:0]      word_o,
    output logic             word_valid_o
);
    localparam fsa_pkg::fsa_ref_st_t REF_RST = '{mode: fsa_pkg::FSA_IDLE, alert_n: 1'b1, default: '0};

    fsa_pkg::fsa_ref_st_t  r, next_r;
    fsa_pkg::fsa_link_st_t l, next_l;

    logic                  cmd_evt;
    logic                  rd_evt;
    logic                  xack_evt;
    logic                  smp_tick;
    logic                  tmp_tick;
    logic                  high_evt;
    logic signed [31:0]    mean32;
    logic [15:0]           mean;
    logic [15:0]           cur_flow;
    logic [15:0]           flags;
    logic signed [24:0]    ema_dq;
    logic signed [42:0]    ema_prod;
    logic signed [23:0]    ema_next;
    logic [15:0]           abs_flow;
    logic                  fifo_in_valid;
    logic                  fifo_in_ready;
    logic [15:0]           fifo_in_data;
    logic                  fifo_out_valid;
    logic [15:0]           fifo_out_data;

    // Events seen on the synchronised toggles
    assign cmd_evt  = r.cmd_s ^ r.cmd_seen;
    assign rd_evt   = r.rd_s ^ r.rd_seen;
    assign xack_evt = r.xack_s ^ r.xack_seen;

    // Sampling loop ticks while running
    assign smp_tick = (r.mode == fsa_pkg::FSA_RUN) && (r.smp_cnt == `FSA_SMP_W'(SAMPLE_CYC - 1));
    assign tmp_tick = (r.mode == fsa_pkg::FSA_RUN) && (r.tmp_cnt == `FSA_TMP_W'(TEMP_CYC - 1));

    // Flow beyond the output limit in either direction
    assign abs_flow = flow_adc_i[15] ? 16'(-flow_adc_i) : flow_adc_i;
    assign high_evt = smp_tick && (abs_flow > `FSA_FLOW_LIMIT);

    // Arithmetic mean of the samples since the last readout
    assign mean32 = (r.cnt == 16'h0000) ? 32'sh00000000 : r.sum / $signed({16'h0000, r.cnt});
    assign mean   = mean32[15:0];

    // Exponential smoothing step in Q8, factor in Q16
    assign ema_dq   = $signed({flow_adc_i[15], flow_adc_i, 8'h00}) - $signed({r.ema_s[23], r.ema_s});
    assign ema_prod = ema_dq * $signed({1'b0, `FSA_ALPHA_Q16});
    assign ema_next = r.ema_s + 24'(ema_prod >>> 16);

    // Value handed out: smoothed, mean, or last value when no sample arrived
    assign cur_flow = r.ema ? r.ema_s[23:8] : ((r.cnt != 16'h0000) ? mean : r.last_flow);

    // Signaling flag word
    always_comb begin
        flags                = 16'h0000;
        flags[`FSA_FLG_AIR]  = r.f_air;
        flags[`FSA_FLG_HIGH] = r.f_high;
        flags[`FSA_FLG_EMA]  = r.ema;
    end

    // FIFO feed: flow, temperature, flags in that order
    assign fifo_in_valid = (r.push_idx != 2'h0);
    always_comb begin
        case (r.push_idx)
            2'h3:    fifo_in_data = r.snap.flow;
            2'h2:    fifo_in_data = r.snap.temp;
            default: fifo_in_data = r.snap.flags;
        endcase
    end

    fsa_fifo #(
        .W (`FSA_WORD_W),
        .D (`FSA_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (!r.xbusy),
        .out_data_o  (fifo_out_data)
    );

    // Measurement domain next state
    always_comb begin
        next_r = r;
        // Synchronisers from the link domain and the pins
        next_r.cmd_m     = l.cmd_tgl;
        next_r.cmd_s     = r.cmd_m;
        next_r.cmd_seen  = r.cmd_s;
        next_r.rd_m      = l.rd_tgl;
        next_r.rd_s      = r.rd_m;
        next_r.rd_seen   = r.rd_s;
        next_r.xack_m    = l.xack_tgl;
        next_r.xack_s    = r.xack_m;
        next_r.xack_seen = r.xack_s;
        next_r.air_m     = air_det_i;
        next_r.air_s     = r.air_m;
        next_r.en_m      = alert_en_i;
        next_r.en_s      = r.en_m;
        // Power-up delay before the bus is answered
        if (!r.ready) begin
            next_r.pu_cnt = r.pu_cnt + 1'b1;
            if (r.pu_cnt == `FSA_PU_W'(PWRUP_CYC - 1)) begin
                next_r.ready = 1'b1;
            end
        end
        // Start-up timer: first result and warm-up marks
        if (r.mode != fsa_pkg::FSA_IDLE && !r.warm) begin
            next_r.tmr = r.tmr + 1'b1;
            if (r.tmr == `FSA_TMR_W'(WARM_CYC - 1)) begin
                next_r.warm = 1'b1;
            end
        end
        if (r.mode == fsa_pkg::FSA_INIT && r.tmr == `FSA_TMR_W'(INIT_CYC - 1)) begin
            next_r.mode = fsa_pkg::FSA_RUN;
        end
        // Sampling loop and averaging interval
        if (r.mode == fsa_pkg::FSA_RUN) begin
            next_r.smp_cnt = smp_tick ? '0 : r.smp_cnt + 1'b1;
            next_r.tmp_cnt = tmp_tick ? '0 : r.tmp_cnt + 1'b1;
            if (tmp_tick) begin
                next_r.temp = temp_adc_i;
            end
            if (!r.ema && r.ivl != `FSA_IVL_W'(AVG_CYC - 1)) begin
                next_r.ivl = r.ivl + 1'b1;
            end
            if (!r.ema && r.ivl == `FSA_IVL_W'(AVG_CYC - 1) && !smp_tick) begin
                next_r.ema   = 1'b1;
                next_r.ema_s = {cur_flow, 8'h00};
            end
        end
        // Readout: snapshot the result and open a new interval
        if (rd_evt) begin
            next_r.snap      = '{flow: cur_flow, temp: r.temp, flags: flags};
            next_r.last_flow = cur_flow;
            next_r.push_idx  = `FSA_WORDS;
            next_r.sum       = 32'sh00000000;
            next_r.cnt       = 16'h0000;
            next_r.ema       = 1'b0;
            next_r.ivl       = '0;
            next_r.f_air     = 1'b0;
            next_r.f_high    = 1'b0;
            next_r.unread    = 1'b0;
        end
        // New flow sample; a sample in the readout cycle opens the new interval
        if (smp_tick) begin
            if (r.ema && !rd_evt) begin
                next_r.ema_s = ema_next;
            end else begin
                next_r.sum = next_r.sum + 32'(signed'(flow_adc_i));
                next_r.cnt = next_r.cnt + 1'b1;
            end
            next_r.avail  = 1'b1;
            next_r.unread = 1'b1;
        end
        // Sticky failure flags, set wins over the readout clear
        next_r.f_air  = next_r.f_air | (r.air_s && r.mode == fsa_pkg::FSA_RUN);
        next_r.f_high = next_r.f_high | high_evt;
        // Host commands; a device outside idle takes only stop
        if (cmd_evt && r.ready) begin
            if (l.cmd == `FSA_CMD_STOP) begin
                next_r.mode   = fsa_pkg::FSA_IDLE;
                next_r.heater = 1'b0;
                next_r.avail  = 1'b0;
                next_r.unread = 1'b0;
                next_r.warm   = 1'b0;
            end else if (r.mode == fsa_pkg::FSA_IDLE &&
                         (l.cmd == `FSA_CMD_START_H2O || l.cmd == `FSA_CMD_START_IPA)) begin
                next_r.mode    = fsa_pkg::FSA_INIT;
                next_r.heater  = 1'b1;
                next_r.med     = (l.cmd == `FSA_CMD_START_IPA);
                next_r.tmr     = '0;
                next_r.smp_cnt = '0;
                next_r.tmp_cnt = '0;
                next_r.ivl     = '0;
                next_r.sum     = 32'sh00000000;
                next_r.cnt     = 16'h0000;
                next_r.ema     = 1'b0;
                next_r.f_air   = 1'b0;
                next_r.f_high  = 1'b0;
            end
        end
        // New-data alert follows unread results when enabled
        next_r.alert_n = !(r.en_s && next_r.unread);
        // Push the snapshot into the FIFO as the FIFO accepts
        if (r.push_idx != 2'h0 && fifo_in_ready) begin
            next_r.push_idx = r.push_idx - 1'b1;
        end
        // Hand FIFO words to the link one at a time
        if (xack_evt) begin
            next_r.xbusy = 1'b0;
        end
        if (!r.xbusy && fifo_out_valid) begin
            next_r.xdat  = fifo_out_data;
            next_r.xreq  = !r.xreq;
            next_r.xbusy = 1'b1;
        end
    end

    // Measurement domain register
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= REF_RST;
        end else begin
            r <= next_r;
        end
    end

    // Link domain next state
    always_comb begin
        next_l           = l;
        next_l.hdr_ack   = 1'b0;
        next_l.hdr_nack  = 1'b0;
        next_l.rdy_m     = r.ready;
        next_l.rdy_s     = l.rdy_m;
        next_l.avl_m     = r.avail;
        next_l.avl_s     = l.avl_m;
        next_l.xreq_m    = r.xreq;
        next_l.xreq_s    = l.xreq_m;
        next_l.xreq_seen = l.xreq_s;
        // Commands are ignored until power-up completes
        if (cmd_valid_i && l.rdy_s) begin
            next_l.cmd     = cmd_i;
            next_l.cmd_tgl = !l.cmd_tgl;
        end
        // Word taken by the host, or dropped by an early stop
        if (l.word_valid && (word_ready_i || rd_stop_i)) begin
            next_l.word_valid = 1'b0;
            next_l.xack_tgl   = !l.xack_tgl;
            if (l.out_cnt == 2'h0) begin
                next_l.reading = 1'b0;
            end
        end
        if (rd_stop_i) begin
            next_l.reading = 1'b0;
        end
        // Word arriving from the measurement domain
        if (l.xreq_s ^ l.xreq_seen) begin
            next_l.out_cnt = l.out_cnt - 1'b1;
            if (l.reading && !rd_stop_i) begin
                next_l.word       = r.xdat;
                next_l.word_valid = 1'b1;
            end else begin
                next_l.xack_tgl = !next_l.xack_tgl;
            end
        end
        // Read header: acknowledged only with a result and an idle link
        if (rd_hdr_i) begin
            if (l.rdy_s && l.avl_s && l.out_cnt == 2'h0 && !l.reading) begin
                next_l.hdr_ack = 1'b1;
                next_l.reading = 1'b1;
                next_l.out_cnt = `FSA_WORDS;
                next_l.rd_tgl  = !l.rd_tgl;
            end else begin
                next_l.hdr_nack = 1'b1;
            end
        end
    end

    // Link domain register
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // Outputs straight from registers
    assign heater_on_o          = r.heater;
    assign medium_ipa_o         = r.med;
    assign warm_o               = r.warm;
    assign new_result_alert_n_o = r.alert_n;
    assign hdr_ack_o            = l.hdr_ack;
    assign hdr_nack_o           = l.hdr_nack;
    assign word_o               = l.word;
    assign word_valid_o         = l.word_valid;
endmodule
`default_nettype wire

// file: bench/fsa_monitor.sv
// Port checker of the flow sample averager
`timescale 1ns/1ps
`default_nettype none
module fsa_monitor #(
    parameter int unsigned INIT_CYC = 50,
    parameter int unsigned WARM_CYC = 250
) (
    // Clocks and reset
    input wire logic        ref_clk_i,
    input wire logic        link_clk_i,
    input wire logic        rst_n_i,
    // Pins and status
    input wire logic        alert_en_i,
    input wire logic        heater_on_o,
    input wire logic        warm_o,
    input wire logic        new_result_alert_n_o,
    // Host link
    input wire logic        rd_hdr_i,
    input wire logic        rd_stop_i,
    input wire logic        word_ready_i,
    input wire logic        hdr_ack_o,
    input wire logic        hdr_nack_o,
    input wire logic [15:0] word_o,
    input wire logic        word_valid_o
);
    localparam int INIT_LO = int'(INIT_CYC) - 10;
    localparam int WARM_LO = int'(WARM_CYC) - 10;
    localparam int WARM_HI = int'(WARM_CYC) + 10;
    logic [31:0] heat_cnt;

    // Ref cycles since the heater came on, saturating
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            heat_cnt <= 32'h00000000;
        end else if (!heater_on_o) begin
            heat_cnt <= 32'h00000000;
        end else if (heat_cnt != 32'hFFFFFFFF) begin
            heat_cnt <= heat_cnt + 32'h00000001;
        end
    end

    // A word offered and not yet taken nor aborted
    sequence s_word_wait;
        word_valid_o && !word_ready_i && !rd_stop_i;
    endsequence

    // Link side answers
    a_hdr_one_answer: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        rd_hdr_i |=> (hdr_ack_o ^ hdr_nack_o)) else $error("header not answered once");
    a_ack_one_cycle: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        hdr_ack_o |=> !hdr_ack_o) else $error("header ack longer than one cycle");
    a_nack_when_idle: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        rd_hdr_i && !heater_on_o && !$past(heater_on_o, 4) |=> hdr_nack_o) else $error("idle header not refused");
    a_nack_during_init: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        rd_hdr_i && heater_on_o && heat_cnt < 32'(INIT_LO) |=> hdr_nack_o) else $error("header taken in init");
    a_word_held: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        s_word_wait |=> word_valid_o && $stable(word_o)) else $error("word dropped or changed while waiting");
    a_word_taken: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        word_valid_o && word_ready_i |=> !word_valid_o) else $error("word still offered after take");
    // Measurement side timing
    a_warm_not_early: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(warm_o) |-> heater_on_o && heat_cnt >= 32'(WARM_LO)) else $error("warm flag too early");
    a_warm_on_time: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        heater_on_o && heat_cnt == 32'(WARM_HI) |-> warm_o) else $error("warm flag late");
    a_alert_needs_en: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !new_result_alert_n_o |-> alert_en_i || $past(alert_en_i, 1) || $past(alert_en_i, 2)
        || $past(alert_en_i, 3) || $past(alert_en_i, 4)) else $error("alert low while disabled");
endmodule
bind fsa_top fsa_monitor #(.INIT_CYC(INIT_CYC), .WARM_CYC(WARM_CYC)) u_mon (
    .ref_clk_i(ref_clk_i), .link_clk_i(link_clk_i), .rst_n_i(rst_n_i), .alert_en_i(alert_en_i),
    .heater_on_o(heater_on_o), .warm_o(warm_o), .new_result_alert_n_o(new_result_alert_n_o),
    .rd_hdr_i(rd_hdr_i), .rd_stop_i(rd_stop_i), .word_ready_i(word_ready_i), .hdr_ack_o(hdr_ack_o),
    .hdr_nack_o(hdr_nack_o), .word_o(word_o), .word_valid_o(word_valid_o));
`default_nettype wire

// file: bench/fsa_host_model.sv
// Host controller model driving the link side of the averager
`timescale 1ns/1ps
`default_nettype none
module fsa_host_model (
    // Link clock
    input  wire logic        link_clk_i,
    // Requests to the device
    output var logic         cmd_valid_o,
    output var logic [15:0]  cmd_o,
    output var logic         rd_hdr_o,
    output var logic         rd_stop_o,
    output var logic         word_ready_o,
    // Answers from the device
    input  wire logic        hdr_ack_i,
    input  wire logic [15:0] word_i,
    input  wire logic        word_valid_i
);
    // Idle levels from time zero
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = 16'h0000;
        rd_hdr_o = 1'b0;
        rd_stop_o = 1'b0;
        word_ready_o = 1'b0;
    end

    // One command word, then the spacing that lets it cross
    task automatic send_cmd(input logic [15:0] c);
        @(negedge link_clk_i);
        cmd_o = c;
        cmd_valid_o = 1'b1;
        @(negedge link_clk_i);
        cmd_valid_o = 1'b0;
        cmd_o = ~c;
        repeat (10) @(negedge link_clk_i);
    endtask

    // Header, then n words with an optional stall before each take
    task automatic read_res(input int n, input int stall, output logic ack, output fsa_pkg::fsa_result_t r);
        logic [15:0] w [3];
        int k;
        int t;
        w = '{16'h0000, 16'h0000, 16'h0000};
        @(negedge link_clk_i);
        rd_hdr_o = 1'b1;
        @(negedge link_clk_i);
        rd_hdr_o = 1'b0;
        ack = hdr_ack_i;
        for (k = 0; k < n && ack === 1'b1; k++) begin
            t = 0;
            while (word_valid_i !== 1'b1 && t < 200) begin
                @(negedge link_clk_i);
                t++;
            end
            repeat (stall) @(negedge link_clk_i);
            w[k] = word_i;
            word_ready_o = 1'b1;
            @(negedge link_clk_i);
            word_ready_o = 1'b0;
        end
        // Early end drops the remaining words
        if (ack === 1'b1 && n < 3) begin
            rd_stop_o = 1'b1;
            @(negedge link_clk_i);
            rd_stop_o = 1'b0;
        end
        r = {w[0], w[1], w[2]};
        repeat (30) @(negedge link_clk_i);
    endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Testbench of the flow sample averager
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                 ref_clk_i, link_clk_i, rst_n_i, air_det_i, alert_en_i;
    logic [15:0]          flow_adc_i, temp_adc_i, cmd_i, word_o;
    logic                 heater_on_o, medium_ipa_o, warm_o, new_result_alert_n_o;
    logic                 cmd_valid_i, rd_hdr_i, rd_stop_i, word_ready_i, hdr_ack_o, hdr_nack_o, word_valid_o;
    logic                 ack;
    fsa_pkg::fsa_result_t r;
    int                   bad_count = 0;
    int                   n_tests = 0;

    // Clocks of unrelated phase
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        link_clk_i = 1'b0;
        #1.3;
        forever #3 link_clk_i = ~link_clk_i;
    end

    // Shortened counts handed to the device, and through the bind to the monitor
    localparam int unsigned SMP_CYC = 20, TMP_CYC = 200, AVG_CYC = 400, PU_CYC = 30, INI_CYC = 50, WRM_CYC = 250;

    // Device with shortened counts
    fsa_top #(.SAMPLE_CYC(SMP_CYC), .TEMP_CYC(TMP_CYC), .AVG_CYC(AVG_CYC), .PWRUP_CYC(PU_CYC), .INIT_CYC(INI_CYC),
              .WARM_CYC(WRM_CYC)) uut (
        .ref_clk_i(ref_clk_i), .link_clk_i(link_clk_i), .rst_n_i(rst_n_i), .flow_adc_i(flow_adc_i),
        .temp_adc_i(temp_adc_i), .air_det_i(air_det_i), .alert_en_i(alert_en_i), .heater_on_o(heater_on_o),
        .medium_ipa_o(medium_ipa_o), .warm_o(warm_o), .new_result_alert_n_o(new_result_alert_n_o),
        .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .rd_hdr_i(rd_hdr_i), .rd_stop_i(rd_stop_i),
        .word_ready_i(word_ready_i), .hdr_ack_o(hdr_ack_o), .hdr_nack_o(hdr_nack_o), .word_o(word_o),
        .word_valid_o(word_valid_o));
    fsa_host_model host (
        .link_clk_i(link_clk_i), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i), .rd_hdr_o(rd_hdr_i),
        .rd_stop_o(rd_stop_i), .word_ready_o(word_ready_i), .hdr_ack_i(hdr_ack_o), .word_i(word_o),
        .word_valid_i(word_valid_o));

    // Compare and count
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask

    // Verdict and end of run
    task automatic final_report;
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Ref cycles at the falling edge
    task automatic wait_ref(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    // Watchdog
    initial begin
        #100000;
        bad_count++;
        final_report;
    end

    // Main sequence
    initial begin
        flow_adc_i = 16'h0064;
        temp_adc_i = 16'h1234;
        air_det_i = 1'b0;
        alert_en_i = 1'b1;
        rst_n_i = 1'b0;
        wait_ref(6);
        rst_n_i = 1'b1;
        chk("heater", 16'h0000, 16'(heater_on_o));
        chk("alert", 16'h0001, 16'(new_result_alert_n_o));
        host.read_res(3, 0, ack, r);
        chk("ack_powerup", 16'h0000, 16'(ack));
        wait_ref(60);
        host.read_res(3, 0, ack, r);
        chk("ack_idle", 16'h0000, 16'(ack));
        host.send_cmd(16'h1234);
        wait_ref(10);
        chk("heater_unknown", 16'h0000, 16'(heater_on_o));
        host.send_cmd(16'h3608);
        wait_ref(10);
        chk("heater_on", 16'h0001, 16'(heater_on_o));
        chk("medium", 16'h0000, 16'(medium_ipa_o));
        chk("warm_early", 16'h0000, 16'(warm_o));
        host.read_res(3, 0, ack, r);
        chk("ack_init", 16'h0000, 16'(ack));
        host.send_cmd(16'h3615);
        chk("medium_busy", 16'h0000, 16'(medium_ipa_o));
        wait_ref(120);
        chk("alert_new", 16'h0000, 16'(new_result_alert_n_o));
        host.read_res(3, 0, ack, r);
        chk("ack_first", 16'h0001, 16'(ack));
        chk("flow_first", 16'h0064, r.flow);
        wait_ref(60);
        host.read_res(3, 3, ack, r);
        chk("flow_mean", 16'h0064, r.flow);
        chk("temp", 16'h1234, r.temp);
        chk("flags_clean", 16'h0000, r.flags);
        // Air and high flow burst, then back to normal
        wait_ref(1);
        flow_adc_i = 16'h0D00;
        air_det_i = 1'b1;
        wait_ref(70);
        flow_adc_i = 16'h0064;
        air_det_i = 1'b0;
        wait_ref(60);
        host.read_res(3, 0, ack, r);
        chk("flags_fail", 16'h0003, r.flags);
        wait_ref(60);
        host.read_res(3, 0, ack, r);
        chk("flow_cleared", 16'h0064, r.flow);
        chk("flags_cleared", 16'h0000, r.flags);
        chk("warm", 16'h0001, 16'(warm_o));
        // Long gap: smoothing takes over
        wait_ref(1);
        temp_adc_i = 16'h0ABC;
        wait_ref(520);
        host.read_res(3, 0, ack, r);
        chk("flow_smooth", 16'h0064, r.flow);
        chk("temp_latest", 16'h0ABC, r.temp);
        chk("flags_smooth", 16'h0020, r.flags);
        wait_ref(60);
        host.read_res(3, 0, ack, r);
        chk("flags_mean", 16'h0000, r.flags);
        wait_ref(1);
        alert_en_i = 1'b0;
        wait_ref(40);
        chk("alert_off", 16'h0001, 16'(new_result_alert_n_o));
        alert_en_i = 1'b1;
        // Stop, then restart with the other calibration
        host.send_cmd(16'h3FF9);
        wait_ref(10);
        chk("heater_stop", 16'h0000, 16'(heater_on_o));
        chk("warm_stop", 16'h0000, 16'(warm_o));
        host.read_res(3, 0, ack, r);
        chk("ack_stopped", 16'h0000, 16'(ack));
        host.send_cmd(16'h3615);
        wait_ref(10);
        chk("medium_ipa", 16'h0001, 16'(medium_ipa_o));
        wait_ref(120);
        host.read_res(1, 2, ack, r);
        chk("ack_short", 16'h0001, 16'(ack));
        chk("flow_short", 16'h0064, r.flow);
        host.read_res(3, 0, ack, r);
        chk("ack_after_short", 16'h0001, 16'(ack));
        final_report;
    end
endmodule
`default_nettype wire
